/* eal_adder8.sv */
`timescale 1ns/1ps
`default_nettype none

module eal_adder8
  import eal_pkg::*;
(
  input wire eal_byte_t a,
  input wire eal_byte_t b,
  input wire logic cin,
  input wire logic sub,
  output eal_byte_t sum,
  output logic carry,
  output logic half,
  output logic ovf
);

  logic [7:0] b_eff;
  logic cin_eff;
  logic [8:0] full;
  logic [4:0] low;

  // Subtract as a plus inverted b plus inverted borrow
  assign b_eff = sub ? ~b : b;
  assign cin_eff = sub ? ~cin : cin;
  assign full = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
  assign low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};

  // Carry and half carry turn into borrows when subtracting
  assign sum = full[7:0];
  assign carry = sub ? ~full[8] : full[8];
  assign half = sub ? ~low[4] : low[4];
  assign ovf = (a[7] == b_eff[7]) && (full[7] != a[7]);

endmodule // eal_adder8

`default_nettype wire

/* eal_alu_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module eal_alu_assertions
  import eal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire eal_req_t req,
  input wire logic req_ready,
  input wire logic wr_valid,
  input wire eal_wr_t wr,
  input wire eal_flags_t flags,
  input wire logic op_illegal
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire logic take;
  wire logic word_op;
  wire logic byte_op;
  wire logic logic_op;
  assign take = req_valid && req_ready;
  assign word_op = req.op inside {EAL_OP_WORD_IMMEDIATE_SUM, EAL_OP_WORD_IMMEDIATE_DIFFERENCE};
  assign byte_op = !word_op && req.op <= EAL_OP_ZERO_REGISTER;
  assign logic_op = req.op inside {EAL_OP_AND, EAL_OP_CONJUNCTION_IMMEDIATE, EAL_OP_OR, EAL_OP_UNION_IMMEDIATE,
    EAL_OP_BITWISE_XOR, EAL_OP_BITS_SET_MASK, EAL_OP_BITS_CLEAR_MASK, EAL_OP_ZERO_SIGN_CHECK, EAL_OP_ZERO_REGISTER};

  // Two write-backs, second one with ready back
  sequence s_word_pair;
    wr_valid && !req_ready ##1 wr_valid && req_ready;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_byte_one_cycle: assert property (take && byte_op |=> wr_valid && wr.addr == $past(req.dst_idx) && $stable(flags.s))
    else $error("byte op write-back late or sign flag moved");
  a_add_sum: assert property (take && req.op == EAL_OP_ADD |=> wr.data == $past(req.dst_val) + $past(req.source_reg))
    else $error("add result wrong");
  a_word_two_writes: assert property (take && word_op |=> s_word_pair)
    else $error("word op did not write two bytes");
  a_word_hi_addr: assert property (take && word_op |-> ##2 wr.addr == $past(req.dst_idx, 2) + 5'h01)
    else $error("word high byte address wrong");
  a_word_flags_hold: assert property (take && word_op |=> $stable(flags))
    else $error("flags moved after word low byte");
  a_logic_no_ovf: assert property (take && logic_op |=> !flags.v && $stable(flags.c))
    else $error("logic op overflow or carry wrong");
  a_carry_kept: assert property (take && req.op inside {EAL_OP_INCREMENT, EAL_OP_MINUS_ONE} |=> $stable(flags.c))
    else $error("increment or decrement moved carry");
  a_clear_zero: assert property (take && req.op == EAL_OP_ZERO_REGISTER |=> wr.data == 8'h00 && flags.z)
    else $error("clear did not give zero");
  a_ones_carry: assert property (take && req.op == EAL_OP_ONES_INVERT |=> flags.c && wr.data == ~$past(req.dst_val))
    else $error("ones invert wrong");
endmodule // eal_alu_assertions

bind eal_alu_core eal_alu_assertions eal_alu_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .wr_valid(wr_valid), .wr(wr), .flags(flags), .op_illegal(op_illegal));

`default_nettype wire

/* eal_alu_core.sv */
// Contract
// - Add and add-with-carry write sum, update Z C N V H, one cycle.
// - Word immediate sum adds constant to register pair, updates Z C N V S, two cycles.
// - Subtract register or immediate into destination, updates Z C N V H, one cycle.
// - Borrow difference also subtracts carry, updates Z C N V H, one cycle.
// - Word immediate difference subtracts constant from pair, updates Z C N V S, two cycles.
// - AND with register or immediate updates only Z N V, one cycle.
// - OR forms and register XOR update only Z N V, one cycle.
// - Bit set ORs mask, bit clear ANDs with FF minus mask; Z N V.
// - Increment and decrement update only Z N V, carry kept, one cycle.
// - Test ANDs register with itself, clear XORs to zero; Z N V.
`timescale 1ns/1ps
`include "eal_defines.svh"
`default_nettype none

module eal_alu_core
  import eal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire eal_req_t req,
  output logic req_ready,
  output logic wr_valid,
  output eal_wr_t wr,
  output eal_flags_t flags,
  output logic op_illegal
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Byte equals zero
  function automatic logic eal_is_zero(input eal_byte_t v);
    return (v == `EAL_BYTE_ZERO);
  endfunction

  // Update only the flags selected by the mask
  function automatic logic [5:0] eal_merge(input logic [5:0] old_v, input logic [5:0] val, input logic [5:0] mask);
    return (old_v & ~mask) | (val & mask);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  eal_state_t state_q;
  eal_state_t state_d;
  eal_flags_t flags_q;
  eal_flags_t flags_d;
  eal_byte_t hi_q;
  eal_reg_idx_t hi_idx_q;
  logic carry_q;
  logic word_sub_q;
  logic lo_zero_q;
  logic wr_valid_q;
  eal_wr_t wr_q;
  eal_wr_t wr_d;
  logic illegal_q;

  eal_op_t op;
  logic take;
  logic in_hi;
  logic op_word_sum;
  logic op_word_diff;
  logic op_word;
  logic op_carry_in;
  logic op_sub;
  logic op_arith8;
  logic op_step;
  logic op_ones;
  logic op_and_cls;
  logic op_or_cls;
  logic op_xor_cls;
  logic op_logic;
  logic op_imm;
  logic op_known;

  eal_byte_t add_a;
  eal_byte_t add_b;
  logic add_cin;
  logic add_sub;
  eal_byte_t add_sum;
  logic add_carry;
  logic add_half;
  logic add_ovf;

  eal_byte_t opnd;
  eal_byte_t and_res;
  eal_byte_t or_res;
  eal_byte_t xor_res;
  eal_byte_t clear_res;
  eal_byte_t ones_res;
  eal_byte_t logic_res;
  eal_byte_t byte_res;
  logic [5:0] byte_val;
  logic [5:0] byte_mask;
  logic [5:0] word_val;
  logic byte_v;
  logic byte_c;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------

  // Handshake and sequencing state
  assign op = req.op;
  assign in_hi = (state_q == EAL_ST_WORD_HI);
  assign req_ready = (state_q == EAL_ST_IDLE);
  assign take = req_valid && req_ready;

  // Word pair operations
  assign op_word_sum = (op == EAL_OP_WORD_IMMEDIATE_SUM);
  assign op_word_diff = (op == EAL_OP_WORD_IMMEDIATE_DIFFERENCE);
  assign op_word = op_word_sum || op_word_diff;

  // Carry-consuming forms
  assign op_carry_in = (op == EAL_OP_ADD_CARRY) || (op == EAL_OP_BORROW_DIFFERENCE)
                    || (op == EAL_OP_BORROW_DIFFERENCE_IMMEDIATE);

  // Adder runs as subtractor
  assign op_sub = (op == EAL_OP_SUBTRACT) || (op == EAL_OP_DIFFERENCE_IMMEDIATE)
               || (op == EAL_OP_BORROW_DIFFERENCE) || (op == EAL_OP_BORROW_DIFFERENCE_IMMEDIATE)
               || (op == EAL_OP_TWOS_INVERT) || (op == EAL_OP_MINUS_ONE) || op_word_diff;

  // Byte arithmetic with full Z C N V H update
  assign op_arith8 = (op == EAL_OP_ADD) || (op == EAL_OP_ADD_CARRY)
                  || (op == EAL_OP_SUBTRACT) || (op == EAL_OP_DIFFERENCE_IMMEDIATE)
                  || (op == EAL_OP_BORROW_DIFFERENCE) || (op == EAL_OP_BORROW_DIFFERENCE_IMMEDIATE)
                  || (op == EAL_OP_TWOS_INVERT);

  // Increment and decrement
  assign op_step = (op == EAL_OP_INCREMENT) || (op == EAL_OP_MINUS_ONE);
  assign op_ones = (op == EAL_OP_ONES_INVERT);

  // Logic classes
  assign op_and_cls = (op == EAL_OP_AND) || (op == EAL_OP_CONJUNCTION_IMMEDIATE)
                   || (op == EAL_OP_ZERO_SIGN_CHECK);
  assign op_or_cls = (op == EAL_OP_OR) || (op == EAL_OP_UNION_IMMEDIATE)
                  || (op == EAL_OP_BITS_SET_MASK);
  assign op_xor_cls = (op == EAL_OP_BITWISE_XOR) || (op == EAL_OP_ZERO_REGISTER);
  assign op_logic = op_and_cls || op_or_cls || op_xor_cls || op_ones
                 || (op == EAL_OP_BITS_CLEAR_MASK);

  // Second operand from the instruction constant
  assign op_imm = (op == EAL_OP_DIFFERENCE_IMMEDIATE) || (op == EAL_OP_BORROW_DIFFERENCE_IMMEDIATE)
               || op_word || (op == EAL_OP_CONJUNCTION_IMMEDIATE) || (op == EAL_OP_UNION_IMMEDIATE)
               || (op == EAL_OP_BITS_SET_MASK) || (op == EAL_OP_BITS_CLEAR_MASK);

  assign op_known = op_word || op_arith8 || op_step || op_logic;

  // ----------------------------------------
  // Adder operand selection
  // ----------------------------------------

  // Second word cycle adds the stored carry to, or subtracts the stored borrow from, the high byte
  assign add_a = in_hi ? hi_q
               : (op == EAL_OP_TWOS_INVERT) ? `EAL_BYTE_ZERO
               : req.dst_val;
  assign add_b = in_hi ? `EAL_BYTE_ZERO
               : (op == EAL_OP_TWOS_INVERT) ? req.dst_val
               : op_step ? `EAL_BYTE_ONE
               : op_imm ? req.imm
               : req.source_reg;
  assign add_cin = in_hi ? carry_q
                 : op_carry_in ? flags_q.c
                 : 1'b0;
  assign add_sub = in_hi ? word_sub_q : op_sub;

  eal_adder8 u_adder (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sub(add_sub),
    .sum(add_sum),
    .carry(add_carry),
    .half(add_half),
    .ovf(add_ovf)
  );

  // ----------------------------------------
  // Logic unit
  // ----------------------------------------

  // Register or constant second operand
  assign opnd = op_imm ? req.imm : req.source_reg;

  // Test ANDs the register with itself
  assign and_res = req.dst_val & ((op == EAL_OP_ZERO_SIGN_CHECK) ? req.dst_val : opnd);
  assign or_res = req.dst_val | opnd;
  // Clear XORs the register with itself
  assign xor_res = req.dst_val ^ ((op == EAL_OP_ZERO_REGISTER) ? req.dst_val : req.source_reg);
  assign clear_res = req.dst_val & (`EAL_BYTE_ALL - req.imm);
  assign ones_res = `EAL_BYTE_ALL - req.dst_val;

  assign logic_res = op_and_cls ? and_res
                   : op_or_cls ? or_res
                   : op_xor_cls ? xor_res
                   : (op == EAL_OP_BITS_CLEAR_MASK) ? clear_res
                   : ones_res;

  // ----------------------------------------
  // Flag results
  // ----------------------------------------

  // Byte result and its flag values
  assign byte_res = (op_arith8 || op_step) ? add_sum : logic_res;
  assign byte_v = (op_arith8 || op_step) ? add_ovf : 1'b0;
  assign byte_c = op_ones ? 1'b1 : add_carry;
  assign byte_val = {add_half, 1'b0, byte_v, byte_res[7], eal_is_zero(byte_res), byte_c};

  // Which flags the byte operation may touch
  assign byte_mask = op_arith8 ? `EAL_MASK_ARITH
                   : op_ones ? `EAL_MASK_ONES
                   : (op_step || op_logic) ? `EAL_MASK_LOGIC
                   : `EAL_MASK_NONE;

  // Word flags from the high-byte pass and the saved low-byte zero
  assign word_val = {1'b0, add_sum[7] ^ add_ovf, add_ovf, add_sum[7],
                     lo_zero_q && eal_is_zero(add_sum), add_carry};

  // Next flag state
  always_comb
  begin
    flags_d = flags_q;
    if (in_hi)
    begin
      flags_d = eal_flags_t'(eal_merge(flags_q, word_val, `EAL_MASK_WORD));
    end
    else if (take && !op_word)
    begin
      flags_d = eal_flags_t'(eal_merge(flags_q, byte_val, byte_mask));
    end
  end

  // ----------------------------------------
  // Write-back selection
  // ----------------------------------------

  // Low byte goes to the named register, high byte to the next one
  always_comb
  begin
    wr_d.addr = req.dst_idx;
    wr_d.data = op_word ? add_sum : byte_res;
    if (in_hi)
    begin
      wr_d.addr = hi_idx_q;
      wr_d.data = add_sum;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------

  // Word operations hold off requests for their second cycle
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      EAL_ST_IDLE:
      begin
        if (take && op_word)
        begin
          state_d = EAL_ST_WORD_HI;
        end
      end
      EAL_ST_WORD_HI:
      begin
        state_d = EAL_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // State and flags
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= EAL_ST_IDLE;
      flags_q <= eal_flags_t'(`EAL_FLAGS_RST);
    end
    else
    begin
      state_q <= state_d;
      flags_q <= flags_d;
    end
  end

  // Word high-byte context captured with the low byte
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_q <= `EAL_BYTE_RST;
      hi_idx_q <= `EAL_IDX_RST;
      carry_q <= 1'b0;
      word_sub_q <= 1'b0;
      lo_zero_q <= 1'b0;
    end
    else if (take && op_word)
    begin
      hi_q <= req.dst_hi_val;
      hi_idx_q <= req.dst_idx + `EAL_IDX_ONE;
      carry_q <= add_carry;
      word_sub_q <= op_word_diff;
      lo_zero_q <= eal_is_zero(add_sum);
    end
  end

  // Write-back port and illegal-code pulse
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_valid_q <= 1'b0;
      wr_q <= '0;
      illegal_q <= 1'b0;
    end
    else
    begin
      wr_valid_q <= (take && op_known) || in_hi;
      wr_q <= wr_d;
      illegal_q <= take && !op_known;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wr_valid = wr_valid_q;
  assign wr = wr_q;
  assign flags = flags_q;
  assign op_illegal = illegal_q;

endmodule // eal_alu_core

`default_nettype wire

/* eal_defines.svh */
`ifndef EAL_DEFINES_SVH
`define EAL_DEFINES_SVH

// ----------------------------------------
// Status flag bit positions
// ----------------------------------------
`define EAL_FLAG_C 0
`define EAL_FLAG_Z 1
`define EAL_FLAG_N 2
`define EAL_FLAG_V 3
`define EAL_FLAG_S 4
`define EAL_FLAG_H 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EAL_FLAGS_RST 6'h00
`define EAL_BYTE_RST 8'h00
`define EAL_IDX_RST 5'h00

// ----------------------------------------
// Byte constants
// ----------------------------------------
`define EAL_BYTE_ALL 8'hFF
`define EAL_BYTE_ZERO 8'h00
`define EAL_BYTE_ONE 8'h01
`define EAL_IDX_ONE 5'h01

// ----------------------------------------
// Flag update masks (H S V N Z C)
// ----------------------------------------
`define EAL_MASK_ARITH 6'h2F
`define EAL_MASK_LOGIC 6'h0E
`define EAL_MASK_ONES 6'h0F
`define EAL_MASK_WORD 6'h1F
`define EAL_MASK_NONE 6'h00

// ----------------------------------------
// Timing counts in clock cycles
// ----------------------------------------
`define EAL_CYCLES_BYTE 1
`define EAL_CYCLES_WORD 2

`endif

/* eal_pkg.sv */
package eal_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [4:0] {
    EAL_OP_ADD = 5'h00,
    EAL_OP_ADD_CARRY = 5'h01,
    EAL_OP_WORD_IMMEDIATE_SUM = 5'h02,
    EAL_OP_SUBTRACT = 5'h03,
    EAL_OP_DIFFERENCE_IMMEDIATE = 5'h04,
    EAL_OP_BORROW_DIFFERENCE = 5'h05,
    EAL_OP_BORROW_DIFFERENCE_IMMEDIATE = 5'h06,
    EAL_OP_WORD_IMMEDIATE_DIFFERENCE = 5'h07,
    EAL_OP_AND = 5'h08,
    EAL_OP_CONJUNCTION_IMMEDIATE = 5'h09,
    EAL_OP_OR = 5'h0A,
    EAL_OP_UNION_IMMEDIATE = 5'h0B,
    EAL_OP_BITWISE_XOR = 5'h0C,
    EAL_OP_ONES_INVERT = 5'h0D,
    EAL_OP_TWOS_INVERT = 5'h0E,
    EAL_OP_BITS_SET_MASK = 5'h0F,
    EAL_OP_BITS_CLEAR_MASK = 5'h10,
    EAL_OP_INCREMENT = 5'h11,
    EAL_OP_MINUS_ONE = 5'h12,
    EAL_OP_ZERO_SIGN_CHECK = 5'h13,
    EAL_OP_ZERO_REGISTER = 5'h14
  } eal_op_t;

  typedef logic [4:0] eal_reg_idx_t;
  typedef logic [7:0] eal_byte_t;

  // ----------------------------------------
  // Request, write-back and flag carriers
  // ----------------------------------------
  typedef struct packed {
    eal_op_t op;
    eal_reg_idx_t dst_idx;
    eal_byte_t dst_val;
    eal_byte_t dst_hi_val;
    eal_byte_t source_reg;
    eal_byte_t imm;
  } eal_req_t;

  typedef struct packed {
    eal_reg_idx_t addr;
    eal_byte_t data;
  } eal_wr_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } eal_flags_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    EAL_ST_IDLE = 2'b01,
    EAL_ST_WORD_HI = 2'b10
  } eal_state_t;

endpackage

/* eal_regfile_model.sv */
`timescale 1ns/1ps
`default_nettype none

module eal_regfile_model
  import eal_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_valid,
  input wire eal_wr_t wr,
  input wire eal_reg_idx_t rd_idx,
  output eal_byte_t rd_data
);
  eal_byte_t mem_q [32];

  // Register file absorbs each write-back byte
  always_ff @(posedge ref_clk)
  begin
    if (wr_valid)
    begin
      mem_q[wr.addr] <= wr.data;
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule // eal_regfile_model

`default_nettype wire

/* eight_bit_arith_logic_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module eight_bit_arith_logic_unit_tb
  import eal_pkg::*;
;
  typedef struct {
    eal_op_t op;
    eal_byte_t h;
    eal_byte_t a;
    eal_byte_t b;
    logic [15:0] r;
    logic [5:0] f;
    logic [5:0] m;
  } eal_row_t;

  logic ref_clk;
  logic rst_n;
  logic req_valid;
  eal_req_t req;
  logic req_ready;
  logic wr_valid;
  eal_wr_t wr;
  eal_flags_t flags;
  logic op_illegal;
  eal_reg_idx_t rd_idx;
  eal_byte_t rd_data;
  logic wrd;
  int failures;
  int num_checks;

  // Ordered so carry users see a known carry
  eal_row_t rows [25] = '{
    '{EAL_OP_ADD, 8'h00, 8'hFF, 8'h01, 16'h0000, 6'h23, 6'h2F},
    '{EAL_OP_ADD_CARRY, 8'h00, 8'h10, 8'h20, 16'h0031, 6'h00, 6'h2F},
    '{EAL_OP_SUBTRACT, 8'h00, 8'h10, 8'h20, 16'h00F0, 6'h05, 6'h2F},
    '{EAL_OP_BORROW_DIFFERENCE, 8'h00, 8'h05, 8'h03, 16'h0001, 6'h00, 6'h2F},
    '{EAL_OP_DIFFERENCE_IMMEDIATE, 8'h00, 8'h80, 8'h01, 16'h007F, 6'h28, 6'h2F},
    '{EAL_OP_BORROW_DIFFERENCE_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'h00FF, 6'h25, 6'h2F},
    '{EAL_OP_AND, 8'h00, 8'hF0, 8'h80, 16'h0080, 6'h04, 6'h0E},
    '{EAL_OP_CONJUNCTION_IMMEDIATE, 8'h00, 8'h0F, 8'hF0, 16'h0000, 6'h02, 6'h0E},
    '{EAL_OP_OR, 8'h00, 8'h01, 8'h80, 16'h0081, 6'h04, 6'h0E},
    '{EAL_OP_UNION_IMMEDIATE, 8'h00, 8'h00, 8'h00, 16'h0000, 6'h02, 6'h0E},
    '{EAL_OP_BITWISE_XOR, 8'h00, 8'hFF, 8'h0F, 16'h00F0, 6'h04, 6'h0E},
    '{EAL_OP_ONES_INVERT, 8'h00, 8'h55, 8'h00, 16'h00AA, 6'h05, 6'h0F},
    '{EAL_OP_TWOS_INVERT, 8'h00, 8'h01, 8'h00, 16'h00FF, 6'h25, 6'h2F},
    '{EAL_OP_TWOS_INVERT, 8'h00, 8'h80, 8'h00, 16'h0080, 6'h0D, 6'h2F},
    '{EAL_OP_BITS_SET_MASK, 8'h00, 8'h01, 8'h80, 16'h0081, 6'h04, 6'h0E},
    '{EAL_OP_BITS_CLEAR_MASK, 8'h00, 8'h81, 8'h01, 16'h0080, 6'h04, 6'h0E},
    '{EAL_OP_INCREMENT, 8'h00, 8'h7F, 8'h00, 16'h0080, 6'h0C, 6'h0E},
    '{EAL_OP_MINUS_ONE, 8'h00, 8'h80, 8'h00, 16'h007F, 6'h08, 6'h0E},
    '{EAL_OP_ZERO_SIGN_CHECK, 8'h00, 8'h00, 8'h00, 16'h0000, 6'h02, 6'h0E},
    '{EAL_OP_ZERO_REGISTER, 8'h00, 8'h5A, 8'h00, 16'h0000, 6'h02, 6'h0E},
    '{EAL_OP_WORD_IMMEDIATE_SUM, 8'h12, 8'hFF, 8'h01, 16'h1300, 6'h00, 6'h1F},
    '{EAL_OP_WORD_IMMEDIATE_SUM, 8'hFF, 8'hFF, 8'h01, 16'h0000, 6'h03, 6'h1F},
    '{EAL_OP_WORD_IMMEDIATE_SUM, 8'h7F, 8'hFF, 8'h01, 16'h8000, 6'h0C, 6'h1F},
    '{EAL_OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 8'h00, 8'h01, 16'hFFFF, 6'h15, 6'h1F},
    '{EAL_OP_WORD_IMMEDIATE_DIFFERENCE, 8'h80, 8'h00, 8'h01, 16'h7FFF, 6'h18, 6'h1F}
  };

  eal_alu_core eal_alu_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .wr_valid(wr_valid), .wr(wr), .flags(flags), .op_illegal(op_illegal));
  eal_regfile_model eal_regfile_model_i (.ref_clk(ref_clk), .wr_valid(wr_valid), .wr(wr), .rd_idx(rd_idx),
    .rd_data(rd_data));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until the edge that takes it; ready looked at between edges
  task automatic send(input eal_op_t op, input eal_byte_t h, input eal_byte_t a, input eal_byte_t b);
    @(posedge ref_clk);
    req <= '{op, 5'h03, a, h, b, b};
    req_valid <= 1'b1;
    #1;
    while (req_ready !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    rd_idx = 5'h04;
    failures = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    #1;
    check({req_ready, wr_valid, op_illegal, flags}, 16'h0100);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    $display("reset test done");
    foreach (rows[i])
    begin
      send(rows[i].op, rows[i].h, rows[i].a, rows[i].b);
      wrd = rows[i].op inside {EAL_OP_WORD_IMMEDIATE_SUM, EAL_OP_WORD_IMMEDIATE_DIFFERENCE};
      check({wr_valid, req_ready, wr}, {1'b1, !wrd, 5'h03, rows[i].r[7:0]});
      if (wrd)
      begin
        @(posedge ref_clk);
        #1;
        check({wr_valid, req_ready, wr}, {2'b11, 5'h04, rows[i].r[15:8]});
      end
      check(flags & rows[i].m, rows[i].f & rows[i].m);
      $display("row %0d done", i);
    end
    // Register file stores the last high byte one edge later
    @(posedge ref_clk);
    #1;
    check(rd_data, 16'h007F);
    // Carry of one op feeds the next, back to back
    @(posedge ref_clk);
    req <= '{EAL_OP_ADD, 5'h07, 8'hFF, 8'h00, 8'h01, 8'h01};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req <= '{EAL_OP_ADD_CARRY, 5'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    check({wr_valid, wr, flags}, {1'b1, 5'h08, 8'h01, 6'h10});
    $display("back to back test done");
    // Unlisted code writes nothing, keeps flags
    send(eal_op_t'(5'h15), 8'h00, 8'h00, 8'h00);
    check({op_illegal, wr_valid, flags}, 16'h0090);
    $display("illegal op test done");
    // Mid-run reset clears flags and write-back
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1;
    check({req_ready, wr_valid, op_illegal, flags}, 16'h0100);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    $display("mid reset test done");
    finish_test();
  end

  // Watchdog
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
endmodule // eight_bit_arith_logic_unit_tb

`default_nettype wire
